// *** include/uv_reset_map.vh ***
// register map, field positions, codes and timing for the undervoltage reset select block
// Notes on behaviour
// - four level codes pick thresholds, lowest first
// - undefined code forces full reset after delay
// - bad-code reset restores level register default
// - undervoltage reset keeps level register contents
// - undervoltage flag set by hardware, software clears
// - bad-code reset sets invalid code flag
// - watchdog in fast/slow acts like pin reset
// - watchdog in sleep/idle clears pc, sp only
`ifndef UV_RESET_MAP_VH
`define UV_RESET_MAP_VH
`define ADDR_LEVEL_SEL     12'h000
`define ADDR_CAUSE_FLAGS   12'h004
`define ADDR_STATUS        12'h008
`define LEVEL_POR          8'h55
`define LEVEL_CODE_0       8'h55
`define LEVEL_CODE_1       8'h33
`define LEVEL_CODE_2       8'h99
`define LEVEL_CODE_3       8'haa
`define FLAG_BAD_CODE      1
`define FLAG_UV            2
`define FLAG_MASK          8'h06
`define STATUS_VALID       2
`define STATUS_WDT         3
`define DELAY_NS           1000
`define CLK_PERIOD_NS      10
`define CLR_PULSE_CYC      4'h4
`endif

// *** design/uv_reset_select.v ***
// undervoltage threshold select, bad-code reset sequencing, cause flags and watchdog reset handling
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "uv_reset_map.vh"
module uv_reset_select #(
	parameter integer DELAY_CYC = (`DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	// clock, reset, enable
	input  wire        clk,
	input  wire        rst_b,
	input  wire        clkEn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// asynchronous events from outside
	input  wire        uvDetect,
	input  wire        wdtExpire,
	input  wire        lowPowerMode,
	// outputs
	output reg  [1:0]  thresholdSel,
	output reg         fullResetReq,
	output reg         warmClearReq,
	output reg         watchdogExpiryFlag
);
	// the delay counter is wide enough for any sane delay; the last count is cut to the counter width on purpose
	localparam integer CW = 16;
	localparam integer DELAY_LAST = DELAY_CYC - 1;
	// sequencer states:
	//   run   - normal operation, level writes accepted
	//   wait  - a bad level code was seen, counting the trigger delay
	//   reset - full reset request held high for a fixed pulse
	// the block never resets itself on its own request; the system does
	localparam [1:0] ST_RUN = 2'h0;
	localparam [1:0] ST_WAIT = 2'h1;
	localparam [1:0] ST_RESET = 2'h2;

	reg  [7:0]    levelSel_q;
	reg           uvFlag_q;
	reg           badFlag_q;
	reg  [1:0]    state_q;
	reg  [CW-1:0] cnt_q;
	reg  [3:0]    pulse_q;
	reg  [1:0]    uvSync_q;
	reg  [1:0]    wdtSync_q;
	reg  [1:0]    lpSync_q;
	reg           wdtSeen_q;
	reg           uvSeen_q;

	// level code decode, used for validity and threshold choice
	// bit 2 marks a defined code, bits 1:0 give the threshold index
	// any other pattern decodes to zero, which the sequencer treats as a bad code
	function [2:0] decodeLevel;
		input [7:0] code;
		begin
			case (code)
				`LEVEL_CODE_0: decodeLevel = 3'h4;
				`LEVEL_CODE_1: decodeLevel = 3'h5;
				`LEVEL_CODE_2: decodeLevel = 3'h6;
				`LEVEL_CODE_3: decodeLevel = 3'h7;
				default:       decodeLevel = 3'h0;
			endcase
		end
	endfunction

	wire [2:0] lvlDec    = decodeLevel(levelSel_q);
	wire       codeValid = lvlDec[2];
	wire       wrEn      = psel & penable & pwrite & ~pready;
	wire       rdEn      = psel & penable & ~pwrite & ~pready;
	wire       hitLevel  = (paddr == `ADDR_LEVEL_SEL);
	wire       hitFlags  = (paddr == `ADDR_CAUSE_FLAGS);
	wire       hitStatus = (paddr == `ADDR_STATUS);
	wire       hitAny    = hitLevel | hitFlags | hitStatus;
	wire       uvEvent   = uvSync_q[1] & ~uvSeen_q & codeValid;
	wire       wdtEvent  = wdtSync_q[1] & ~wdtSeen_q;

	// pins from other domains pass two flops before any use
	// only the second flop of each pair feeds logic, so a metastable first stage never spreads
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			uvSync_q  <= 2'h0;
			wdtSync_q <= 2'h0;
			lpSync_q  <= 2'h0;
		end else if (clkEn) begin
			uvSync_q  <= {uvSync_q[0], uvDetect};
			wdtSync_q <= {wdtSync_q[0], wdtExpire};
			lpSync_q  <= {lpSync_q[0], lowPowerMode};
		end
	end

	// apb answers one cycle into the access phase; unmapped addresses error
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else if (clkEn) begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~hitAny;
			if (rdEn) begin
				if (hitLevel)
					prdata <= {24'h0, levelSel_q};
				else if (hitFlags)
					prdata <= {29'h0, uvFlag_q, badFlag_q, 1'b0};
				else if (hitStatus)
					prdata <= {28'h0, watchdogExpiryFlag, codeValid, thresholdSel};
				else
					prdata <= 32'h0;
			end
		end
	end

	// level register: a bad-code reset reloads it, an undervoltage reset leaves it alone
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			levelSel_q <= `LEVEL_POR;
		end else if (clkEn) begin
			if (state_q == ST_RESET && !codeValid)
				levelSel_q <= `LEVEL_POR;
			else if (wrEn && hitLevel && state_q == ST_RUN)
				levelSel_q <= pwdata[7:0];
		end
	end

	// cause flags: hardware sets, software writes 0 to clear; a set in the same cycle wins
	// writing 1 leaves a flag alone, so software may clear one flag without losing the other
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			uvFlag_q  <= 1'b0;
			badFlag_q <= 1'b0;
		end else if (clkEn) begin
			if (uvEvent)
				uvFlag_q <= 1'b1;
			else if (wrEn && hitFlags && !pwdata[`FLAG_UV])
				uvFlag_q <= 1'b0;
			if (state_q == ST_WAIT && cnt_q == DELAY_LAST[CW-1:0])
				badFlag_q <= 1'b1;
			else if (wrEn && hitFlags && !pwdata[`FLAG_BAD_CODE])
				badFlag_q <= 1'b0;
		end
	end

	// reset sequencer: bad code waits the delay, then pulses a full reset
	// a bad code has priority over a pending undervoltage event, since the threshold is then undefined
	// the pulse length is fixed so the system reset logic can rely on it
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q      <= ST_RUN;
			cnt_q        <= {CW{1'b0}};
			pulse_q      <= 4'h0;
			fullResetReq <= 1'b0;
			uvSeen_q     <= 1'b0;
		end else if (clkEn) begin
			uvSeen_q <= uvSync_q[1];
			case (state_q)
				ST_RUN: begin
					cnt_q <= {CW{1'b0}};
					if (!codeValid)
						state_q <= ST_WAIT;
					else if (uvEvent) begin
						state_q      <= ST_RESET;
						pulse_q      <= `CLR_PULSE_CYC;
						fullResetReq <= 1'b1;
					end else if (wdtEvent && !lpSync_q[1]) begin
						state_q      <= ST_RESET;
						pulse_q      <= `CLR_PULSE_CYC;
						fullResetReq <= 1'b1;
					end
				end
				ST_WAIT: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == DELAY_LAST[CW-1:0]) begin
						state_q      <= ST_RESET;
						pulse_q      <= `CLR_PULSE_CYC;
						fullResetReq <= 1'b1;
					end
				end
				ST_RESET: begin
					pulse_q <= pulse_q - 1'b1;
					if (pulse_q == 4'h1) begin
						state_q      <= ST_RUN;
						fullResetReq <= 1'b0;
					end
				end
				default: begin
					state_q      <= ST_RUN;
					fullResetReq <= 1'b0;
				end
			endcase
		end
	end

	// watchdog: expiry flag always set; in low power only pc and sp clear
	// in fast or slow mode the sequencer raises the full reset instead
	// the warm clear is a single cycle pulse; the core must catch it on this clock
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wdtSeen_q          <= 1'b0;
			warmClearReq       <= 1'b0;
			watchdogExpiryFlag <= 1'b0;
		end else if (clkEn) begin
			wdtSeen_q    <= wdtSync_q[1];
			warmClearReq <= wdtEvent & lpSync_q[1];
			if (wdtEvent)
				watchdogExpiryFlag <= 1'b1;
			else if (wrEn && hitStatus && !pwdata[`STATUS_WDT])
				watchdogExpiryFlag <= 1'b0;
		end
	end

	// threshold output follows the register; held while code is bad
	// holding the last good value keeps the detector from swinging to an arbitrary level
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			thresholdSel <= 2'h0;
		else if (clkEn && codeValid)
			thresholdSel <= lvlDec[1:0];
	end
endmodule
`default_nettype wire

// *** testbench/uv_reset_select_monitor.sv ***
// concurrent checks on the ports of the undervoltage reset select block
`timescale 1ns/1ps
`default_nettype none
module uv_reset_select_monitor #(
	parameter integer DELAY_CYC = 100
) (
	// clock, reset, enable
	input wire logic        clk, rst_b, clkEn,
	// apb
	input wire logic        psel, penable, pwrite, pready, pslverr,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	// events and requests
	input wire logic        uvDetect, wdtExpire, lowPowerMode,
	input wire logic        fullResetReq, warmClearReq, watchdogExpiryFlag,
	input wire logic [1:0]  thresholdSel
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// request pulse length is fixed, the system counts on it
	reset_pulse_a: assert property ($rose(fullResetReq) |-> fullResetReq[*4] ##1 !fullResetReq)
		else $error("reset request length wrong");
	apb_answer_a: assert property ((psel && penable && !pready && clkEn) |=> pready)
		else $error("apb answer late");
	err_read_a: assert property ((pready && pslverr && !pwrite) |-> prdata == 32'h0)
		else $error("refused read data not zero");
	wdt_fast_a: assert property (($rose(wdtExpire) && !lowPowerMode) |-> ##[2:6] fullResetReq)
		else $error("watchdog in run gave no reset");
	wdt_sleep_a: assert property (($rose(wdtExpire) && lowPowerMode) |-> ##[2:6] warmClearReq)
		else $error("watchdog in low power gave no clear");
	warm_flag_a: assert property (warmClearReq |=> (!warmClearReq && watchdogExpiryFlag))
		else $error("warm clear pulse or flag wrong");
	// stimulus only raises undervoltage with a valid code
	uv_reset_a: assert property ($rose(uvDetect) |-> ##[2:6] fullResetReq)
		else $error("undervoltage gave no reset");
	flag_sticky_a: assert property ($fell(watchdogExpiryFlag) |-> $past(psel && penable && pwrite))
		else $error("watchdog flag cleared by hardware");
	cover property ($rose(fullResetReq));
	cover property (warmClearReq);
	cover property (pready && pslverr);
endmodule
bind uv_reset_select uv_reset_select_monitor #(.DELAY_CYC(DELAY_CYC)) mon (.clk, .rst_b, .clkEn, .psel,
	.penable, .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .uvDetect, .wdtExpire, .lowPowerMode,
	.fullResetReq, .warmClearReq, .watchdogExpiryFlag, .thresholdSel);
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the undervoltage reset select block
`timescale 1ns/1ps
`default_nettype none
`include "uv_reset_map.vh"
module testbench;
	logic        clk, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        uvDetect = 1'b0, wdtExpire = 1'b0, lowPowerMode = 1'b0, er;
	logic        pready, pslverr, fullResetReq, warmClearReq, watchdogExpiryFlag;
	logic [1:0]  thresholdSel;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [7:0]  codes [4] = '{`LEVEL_CODE_0, `LEVEL_CODE_1, `LEVEL_CODE_2, `LEVEL_CODE_3};
	int          failures, compares;
	// short bad-code delay keeps the run brief
	uv_reset_select #(.DELAY_CYC(3)) DUT (.clk, .rst_b, .clkEn(1'b1), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .uvDetect, .wdtExpire, .lowPowerMode, .thresholdSel,
		.fullResetReq, .warmClearReq, .watchdogExpiryFlag);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one apb transfer, held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// a hang costs a mismatch
	initial begin
		#100000;
		failures++;
		give_verdict;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rdchk(`ADDR_LEVEL_SEL, {24'h0, `LEVEL_POR});
		rdchk(`ADDR_CAUSE_FLAGS, 32'h0);
		// each code picks its threshold, lowest first
		foreach (codes[i]) begin
			apb(1'b1, `ADDR_LEVEL_SEL, {24'h0, codes[i]});
			rdchk(`ADDR_STATUS, 32'h4 | 32'(i));
			chk({30'h0, thresholdSel}, 32'(i));
		end
		uvDetect <= 1'b1;
		repeat (10) @(posedge clk);
		uvDetect <= 1'b0;
		rdchk(`ADDR_CAUSE_FLAGS, 32'h4);
		rdchk(`ADDR_LEVEL_SEL, 32'haa);
		apb(1'b1, `ADDR_CAUSE_FLAGS, 32'h0);
		rdchk(`ADDR_CAUSE_FLAGS, 32'h0);
		// undefined code: delayed reset, default reload
		apb(1'b1, `ADDR_LEVEL_SEL, 32'h12);
		chk({31'h0, fullResetReq}, 32'h0);
		repeat (3) @(posedge clk);
		chk({31'h0, fullResetReq}, 32'h1);
		repeat (14) @(posedge clk);
		rdchk(`ADDR_LEVEL_SEL, {24'h0, `LEVEL_POR});
		rdchk(`ADDR_CAUSE_FLAGS, 32'h2);
		wdtExpire <= 1'b1;
		repeat (10) @(posedge clk);
		wdtExpire <= 1'b0;
		rdchk(`ADDR_STATUS, 32'hc);
		lowPowerMode <= 1'b1;
		apb(1'b1, `ADDR_STATUS, 32'h0);
		wdtExpire <= 1'b1;
		repeat (10) @(posedge clk);
		rdchk(`ADDR_STATUS, 32'hc);
		rdchk(`ADDR_CAUSE_FLAGS, 32'h2);
		rdchk(12'h00c, 32'h0);
		chk({31'h0, er}, 32'h1);
		give_verdict;
	end
endmodule
`default_nettype wire
